// ---- pstm_afe_model.sv ----
// front end model: gates the pack fets, all off once shutdown is ordered
`timescale 1ns/1ps
module pstm_afe_model (
  // orders from the monitor
  input  wire logic i_chg_on,
  input  wire logic i_dsg_on,
  input  wire logic i_shutdown,
  // fet gate levels
  output logic      o_chg_gate,
  output logic      o_dsg_gate
);
  assign o_chg_gate = i_chg_on && !i_shutdown;
  assign o_dsg_gate = i_dsg_on && !i_shutdown;
endmodule

// ---- pstm_defs.svh ----
// register indices, field positions, reset values and timing constants of the threshold monitor
`ifndef PSTM_DEFS_SVH
`define PSTM_DEFS_SVH

// register indices; byte address is four times the index
`define PSTM_IDX_CHG_BLOCK_HOT      10'h047
`define PSTM_IDX_DSG_END_VOLT       10'h067
`define PSTM_IDX_CHG_PAUSE_HOT      10'h06D
`define PSTM_IDX_CHG_PAUSE_RECOVER  10'h06F
`define PSTM_IDX_DRAIN_HOT          10'h071
`define PSTM_IDX_DRAIN_HOT_RECOVER  10'h073
`define PSTM_IDX_FATAL_CHG_HOT      10'h075
`define PSTM_IDX_FATAL_DRAIN_HOT    10'h077
`define PSTM_IDX_IGNORE_BAND        10'h07B
`define PSTM_IDX_POWER_OFF_VOLT     10'h07C
`define PSTM_IDX_TEMP_TRIM          10'h0D6
`define PSTM_IDX_COULOMB_TRIM       10'h0D7
`define PSTM_IDX_CHG_FLOW_THR       10'h113
`define PSTM_IDX_DRAIN_FLOW_THR     10'h115
`define PSTM_IDX_OFF_CHG_LEAK       10'h125
`define PSTM_IDX_OFF_DRAIN_LEAK     10'h127
`define PSTM_IDX_SWITCH_FAULT_SEC   10'h129
`define PSTM_IDX_CONTROL            10'h140
`define PSTM_IDX_STATUS             10'h141
`define PSTM_IDX_START_LOW          10'h142
`define PSTM_IDX_START_HIGH         10'h143

// control register bits
`define PSTM_CTL_FATAL_CHG_EN   0
`define PSTM_CTL_FATAL_DRAIN_EN 1
`define PSTM_CTL_FIXED_BATTERY  2

// status register bits
`define PSTM_ST_PAUSE        0
`define PSTM_ST_DRAIN_HOT    1
`define PSTM_ST_PERM_FAIL    2
`define PSTM_ST_CHG_FET_FAIL 3
`define PSTM_ST_DSG_FET_FAIL 4
`define PSTM_ST_TERM_ALARM   5
`define PSTM_ST_SHUTDOWN     6
`define PSTM_ST_CHARGING     7
`define PSTM_ST_DRAINING     8
`define PSTM_ST_INHIBIT      9
`define PSTM_ST_WAIT_WINDOW  10

// reset values
`define PSTM_RST_WORD  16'h0000
`define PSTM_RST_BYTE  8'h00
`define PSTM_RST_START_HIGH 16'h01C2

// timing
`define PSTM_CLK_NS     40
`define PSTM_SECOND_NS  1000000000

`endif

// ---- pstm_monitor.sv ----
// pack safety threshold monitor with apb register file
//
// Contract
// - over charge-block hot limit, charging current and voltage requests read zero.
// - above charge-pause hot limit while charging, pause charging and flag system present.
// - pause clears on cooling below recover limit, adapter removal or pack removal.
// - after a pause, charging restarts only inside the charge-start temperature window.
// - above drain hot limit, both FETs off and system present flagged.
// - drain hot clears below recover limit, or on removal if battery is removable.
// - charging above fatal charge hot limit with its enable set enters permanent failure.
// - draining above fatal drain hot limit with its enable set enters permanent failure.
// - current above the positive charge threshold counts as charging.
// - current below the negative drain threshold counts as draining; charge FET may stay on.
// - current through an off FET beyond its leak limit for set seconds marks it failed.
// - discharge-end alarm sets below end voltage; clears above it only without cell undervoltage.
// - every temperature sample is corrected by the signed temperature trim.
// - current samples are corrected by the signed coulomb trim.
// - current magnitude under the ignore band counts as no current.
// - below power-off voltage the pack shuts down and all FETs turn off.
// - removable battery failure conditions clear only on pack removal.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "pstm_defs.svh"
module pstm_monitor
  import pstm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PSTM_SECOND_NS / `PSTM_CLK_NS
) (
  // clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  // apb slave
  input  wire logic        i_PSEL,
  input  wire logic        i_PENABLE,
  input  wire logic        i_PWRITE,
  input  wire logic [11:0] i_PADDR,
  input  wire logic [31:0] i_PWDATA,
  output logic             o_PREADY,
  output logic [31:0]      o_PRDATA,
  output logic             o_PSLVERR,
  // measurements, same clock
  input  wire logic        i_MEAS_VALID,
  input  wire logic [15:0] i_TEMP_RAW,
  input  wire logic [15:0] i_CURRENT_RAW,
  input  wire logic [15:0] i_PACK_VOLT,
  input  wire logic        i_CELL_UNDERVOLTAGE_FLAG,
  // charge requests from the gauge
  input  wire logic [15:0] i_REQ_CHG_CURRENT,
  input  wire logic [15:0] i_REQ_CHG_VOLTAGE,
  // pins
  input  wire logic        i_ADAPTER_PRESENT,
  input  wire logic        i_PACK_PRESENT,
  // reported requests
  output logic [15:0]      o_CHG_CURRENT,
  output logic [15:0]      o_CHG_VOLTAGE,
  // front end and status
  output logic             o_CHG_FET_ON,
  output logic             o_DSG_FET_ON,
  output logic             o_SHUTDOWN,
  output logic             o_MANUFACTURER_ACCESS_SYS_PRESENT,
  output logic             o_TERM_DSG_ALARM,
  output logic             o_PERM_FAIL
);

  typedef struct packed {
    logic [15:0] chg_block_hot;
    logic [15:0] dsg_end_volt;
    logic [15:0] chg_pause_hot;
    logic [15:0] chg_pause_recover;
    logic [15:0] drain_hot;
    logic [15:0] drain_hot_recover;
    logic [15:0] fatal_chg_hot;
    logic [15:0] fatal_drain_hot;
    logic [7:0]  ignore_band;
    logic [15:0] power_off_volt;
    logic [7:0]  temp_trim;
    logic [7:0]  coulomb_trim;
    logic [15:0] chg_flow_thr;
    logic [15:0] drain_flow_thr;
    logic [15:0] off_chg_leak;
    logic [15:0] off_drain_leak;
    logic [7:0]  switch_fault_sec;
    logic [2:0]  control;
    logic [15:0] start_low;
    logic [15:0] start_high;
    logic [15:0] temp;
    logic [15:0] current;
    logic [15:0] volt;
    logic        sample_ok;
    chg_state_t  chg_state;
    logic        drain_hot_flag;
    logic        perm_fail;
    logic        term_alarm;
    logic        shutdown;
    logic        present_prev;
    logic        adapter_prev;
    logic [31:0] tick_count;
    logic        tick;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic [15:0] chg_current;
    logic [15:0] chg_voltage;
    logic        chg_fet;
    logic        dsg_fet;
    logic        sys_present;
  } mon_state_t;

  mon_state_t st;
  mon_state_t next_st;

  logic        pack_present;
  logic        adapter_present;
  logic        chg_fet_fail;
  logic        dsg_fet_fail;
  logic        pack_removed;
  logic        adapter_removed;
  logic        charging;
  logic        draining;
  logic        inhibit;
  logic        fixed_battery_select;
  logic        fail_clear;
  logic [15:0] trimmed_temp;
  logic [15:0] trimmed_current;
  logic [15:0] band_abs;
  logic [15:0] status_word;
  logic [9:0]  reg_index;

  // pins arrive asynchronously
  pstm_sync3 u_sync_present (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_pin   (i_PACK_PRESENT),
    .o_level (pack_present)
  );

  pstm_sync3 u_sync_adapter (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_pin   (i_ADAPTER_PRESENT),
    .o_level (adapter_present)
  );

  // current through an off FET, judged against its own leak limit
  pstm_persist #(.W(8)) u_chg_fet_fail (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_cond  (st.sample_ok && !st.chg_fet && ($signed(st.current) > $signed(st.off_chg_leak))),
    .i_tick  (st.tick),
    .i_limit (st.switch_fault_sec),
    .i_clear (fail_clear),
    .o_fired (chg_fet_fail)
  );

  pstm_persist #(.W(8)) u_dsg_fet_fail (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_cond  (st.sample_ok && !st.dsg_fet && ($signed(st.current) < $signed(st.off_drain_leak))),
    .i_tick  (st.tick),
    .i_limit (st.switch_fault_sec),
    .i_clear (fail_clear),
    .o_fired (dsg_fet_fail)
  );

  assign fixed_battery_select = st.control[`PSTM_CTL_FIXED_BATTERY];
  assign pack_removed         = st.present_prev && !pack_present;
  assign adapter_removed      = st.adapter_prev && !adapter_present;
  // removable battery: FET failures clear on removal and nothing else
  assign fail_clear           = pack_removed && !fixed_battery_select;

  // trims applied before any comparison
  assign trimmed_temp    = i_TEMP_RAW + {{8{st.temp_trim[7]}}, st.temp_trim};
  assign trimmed_current = i_CURRENT_RAW + {{8{st.coulomb_trim[7]}}, st.coulomb_trim};
  assign band_abs        = trimmed_current[15] ? 16'(-trimmed_current) : trimmed_current;

  assign charging = st.sample_ok && ($signed(st.current) > $signed(st.chg_flow_thr));
  assign draining = st.sample_ok && ($signed(st.current) < $signed(st.drain_flow_thr));
  assign inhibit  = st.sample_ok && ($signed(st.temp) > $signed(st.chg_block_hot));

  assign reg_index = i_PADDR[11:2];

  always_comb begin
    status_word = '0;
    status_word[`PSTM_ST_PAUSE]        = (st.chg_state == CHG_PAUSED);
    status_word[`PSTM_ST_DRAIN_HOT]    = st.drain_hot_flag;
    status_word[`PSTM_ST_PERM_FAIL]    = st.perm_fail;
    status_word[`PSTM_ST_CHG_FET_FAIL] = chg_fet_fail;
    status_word[`PSTM_ST_DSG_FET_FAIL] = dsg_fet_fail;
    status_word[`PSTM_ST_TERM_ALARM]   = st.term_alarm;
    status_word[`PSTM_ST_SHUTDOWN]     = st.shutdown;
    status_word[`PSTM_ST_CHARGING]     = charging;
    status_word[`PSTM_ST_DRAINING]     = draining;
    status_word[`PSTM_ST_INHIBIT]      = inhibit;
    status_word[`PSTM_ST_WAIT_WINDOW]  = (st.chg_state == CHG_WAIT_WINDOW);
  end

  always_comb begin
    next_st = st;
    next_st.present_prev = pack_present;
    next_st.adapter_prev = adapter_present;

    // one-second time base for FET failure timing
    next_st.tick = 1'b0;
    if (st.tick_count >= TICK_CYCLES - 1) begin
      next_st.tick_count = '0;
      next_st.tick       = 1'b1;
    end else begin
      next_st.tick_count = st.tick_count + 32'h0000_0001;
    end

    // sample capture with deadband
    if (i_MEAS_VALID) begin
      next_st.sample_ok = 1'b1;
      next_st.temp      = trimmed_temp;
      next_st.volt      = i_PACK_VOLT;
      if (band_abs < {8'h00, st.ignore_band}) begin
        next_st.current = 16'h0000;
      end else begin
        next_st.current = trimmed_current;
      end
    end

    // apb: answer in the first access cycle, act at that edge
    next_st.pready  = i_PSEL && !i_PENABLE;
    next_st.pslverr = 1'b0;
    if (i_PSEL && !i_PENABLE) begin
      next_st.prdata = 32'h0000_0000;
      unique case (reg_index)
        `PSTM_IDX_CHG_BLOCK_HOT:     next_st.prdata[15:0] = st.chg_block_hot;
        `PSTM_IDX_DSG_END_VOLT:      next_st.prdata[15:0] = st.dsg_end_volt;
        `PSTM_IDX_CHG_PAUSE_HOT:     next_st.prdata[15:0] = st.chg_pause_hot;
        `PSTM_IDX_CHG_PAUSE_RECOVER: next_st.prdata[15:0] = st.chg_pause_recover;
        `PSTM_IDX_DRAIN_HOT:         next_st.prdata[15:0] = st.drain_hot;
        `PSTM_IDX_DRAIN_HOT_RECOVER: next_st.prdata[15:0] = st.drain_hot_recover;
        `PSTM_IDX_FATAL_CHG_HOT:     next_st.prdata[15:0] = st.fatal_chg_hot;
        `PSTM_IDX_FATAL_DRAIN_HOT:   next_st.prdata[15:0] = st.fatal_drain_hot;
        `PSTM_IDX_IGNORE_BAND:       next_st.prdata[7:0]  = st.ignore_band;
        `PSTM_IDX_POWER_OFF_VOLT:    next_st.prdata[15:0] = st.power_off_volt;
        `PSTM_IDX_TEMP_TRIM:         next_st.prdata[7:0]  = st.temp_trim;
        `PSTM_IDX_COULOMB_TRIM:      next_st.prdata[7:0]  = st.coulomb_trim;
        `PSTM_IDX_CHG_FLOW_THR:      next_st.prdata[15:0] = st.chg_flow_thr;
        `PSTM_IDX_DRAIN_FLOW_THR:    next_st.prdata[15:0] = st.drain_flow_thr;
        `PSTM_IDX_OFF_CHG_LEAK:      next_st.prdata[15:0] = st.off_chg_leak;
        `PSTM_IDX_OFF_DRAIN_LEAK:    next_st.prdata[15:0] = st.off_drain_leak;
        `PSTM_IDX_SWITCH_FAULT_SEC:  next_st.prdata[7:0]  = st.switch_fault_sec;
        `PSTM_IDX_CONTROL:           next_st.prdata[2:0]  = st.control;
        `PSTM_IDX_STATUS:            next_st.prdata[15:0] = status_word;
        `PSTM_IDX_START_LOW:         next_st.prdata[15:0] = st.start_low;
        `PSTM_IDX_START_HIGH:        next_st.prdata[15:0] = st.start_high;
        default:                     next_st.pslverr      = 1'b1;
      endcase
    end
    if (i_PSEL && i_PENABLE && st.pready && i_PWRITE && !st.pslverr) begin
      unique case (reg_index)
        `PSTM_IDX_CHG_BLOCK_HOT:     next_st.chg_block_hot     = i_PWDATA[15:0];
        `PSTM_IDX_DSG_END_VOLT:      next_st.dsg_end_volt      = i_PWDATA[15:0];
        `PSTM_IDX_CHG_PAUSE_HOT:     next_st.chg_pause_hot     = i_PWDATA[15:0];
        `PSTM_IDX_CHG_PAUSE_RECOVER: next_st.chg_pause_recover = i_PWDATA[15:0];
        `PSTM_IDX_DRAIN_HOT:         next_st.drain_hot         = i_PWDATA[15:0];
        `PSTM_IDX_DRAIN_HOT_RECOVER: next_st.drain_hot_recover = i_PWDATA[15:0];
        `PSTM_IDX_FATAL_CHG_HOT:     next_st.fatal_chg_hot     = i_PWDATA[15:0];
        `PSTM_IDX_FATAL_DRAIN_HOT:   next_st.fatal_drain_hot   = i_PWDATA[15:0];
        `PSTM_IDX_IGNORE_BAND:       next_st.ignore_band       = i_PWDATA[7:0];
        `PSTM_IDX_POWER_OFF_VOLT:    next_st.power_off_volt    = i_PWDATA[15:0];
        `PSTM_IDX_TEMP_TRIM:         next_st.temp_trim         = i_PWDATA[7:0];
        `PSTM_IDX_COULOMB_TRIM:      next_st.coulomb_trim      = i_PWDATA[7:0];
        `PSTM_IDX_CHG_FLOW_THR:      next_st.chg_flow_thr      = i_PWDATA[15:0];
        `PSTM_IDX_DRAIN_FLOW_THR:    next_st.drain_flow_thr    = i_PWDATA[15:0];
        `PSTM_IDX_OFF_CHG_LEAK:      next_st.off_chg_leak      = i_PWDATA[15:0];
        `PSTM_IDX_OFF_DRAIN_LEAK:    next_st.off_drain_leak    = i_PWDATA[15:0];
        `PSTM_IDX_SWITCH_FAULT_SEC:  next_st.switch_fault_sec  = i_PWDATA[7:0];
        `PSTM_IDX_CONTROL:           next_st.control           = i_PWDATA[2:0];
        `PSTM_IDX_START_LOW:         next_st.start_low         = i_PWDATA[15:0];
        `PSTM_IDX_START_HIGH:        next_st.start_high        = i_PWDATA[15:0];
        default:                     next_st.control           = st.control;
      endcase
    end

    // charge pause: in the wait window a new pause beats a restart in the same cycle; while paused, a removal clears even when hot
    unique case (st.chg_state)
      CHG_RUN: begin
        if (charging && $signed(st.temp) > $signed(st.chg_pause_hot)) begin
          next_st.chg_state = CHG_PAUSED;
        end
      end
      CHG_PAUSED: begin
        if ($signed(st.temp) < $signed(st.chg_pause_recover) || adapter_removed || pack_removed) begin
          next_st.chg_state = CHG_WAIT_WINDOW;
        end
      end
      CHG_WAIT_WINDOW: begin
        if (charging && $signed(st.temp) > $signed(st.chg_pause_hot)) begin
          next_st.chg_state = CHG_PAUSED;
        end else if ($signed(st.temp) >= $signed(st.start_low) && $signed(st.temp) <= $signed(st.start_high)) begin
          next_st.chg_state = CHG_RUN;
        end
      end
    endcase

    // drain overtemperature
    if (st.sample_ok && $signed(st.temp) > $signed(st.drain_hot)) begin
      next_st.drain_hot_flag = 1'b1;
    end else if ($signed(st.temp) < $signed(st.drain_hot_recover) || (pack_removed && !fixed_battery_select)) begin
      next_st.drain_hot_flag = 1'b0;
    end

    // permanent failure is never cleared short of reset
    if (charging && st.control[`PSTM_CTL_FATAL_CHG_EN] && $signed(st.temp) > $signed(st.fatal_chg_hot)) begin
      next_st.perm_fail = 1'b1;
    end
    if (draining && st.control[`PSTM_CTL_FATAL_DRAIN_EN] && $signed(st.temp) > $signed(st.fatal_drain_hot)) begin
      next_st.perm_fail = 1'b1;
    end

    // discharge-end alarm, unsigned millivolts
    if (st.sample_ok && st.volt < st.dsg_end_volt) begin
      next_st.term_alarm = 1'b1;
    end else if (st.volt > st.dsg_end_volt && !i_CELL_UNDERVOLTAGE_FLAG) begin
      next_st.term_alarm = 1'b0;
    end

    // shutdown latches; the front end removes power, so only reset leaves it
    if (st.sample_ok && st.volt < st.power_off_volt) begin
      next_st.shutdown = 1'b1;
    end

    next_st.chg_current = inhibit ? 16'h0000 : i_REQ_CHG_CURRENT;
    next_st.chg_voltage = inhibit ? 16'h0000 : i_REQ_CHG_VOLTAGE;

    // charge FET may stay on while draining to cut diode losses
    next_st.chg_fet = !(next_st.shutdown || next_st.perm_fail || next_st.drain_hot_flag || chg_fet_fail ||
                        (next_st.chg_state != CHG_RUN && !draining));
    next_st.dsg_fet = !(next_st.shutdown || next_st.perm_fail || next_st.drain_hot_flag || dsg_fet_fail);
    next_st.sys_present = next_st.drain_hot_flag || next_st.chg_state == CHG_PAUSED;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st                   <= '0;
      st.chg_state         <= CHG_RUN;
      st.chg_block_hot     <= `PSTM_RST_WORD;
      st.start_high        <= `PSTM_RST_START_HIGH;
      st.switch_fault_sec  <= `PSTM_RST_BYTE;
    end else begin
      st <= next_st;
    end
  end

  assign o_PREADY                          = st.pready;
  assign o_PRDATA                          = st.prdata;
  assign o_PSLVERR                         = st.pslverr;
  assign o_CHG_CURRENT                     = st.chg_current;
  assign o_CHG_VOLTAGE                     = st.chg_voltage;
  assign o_CHG_FET_ON                      = st.chg_fet;
  assign o_DSG_FET_ON                      = st.dsg_fet;
  assign o_SHUTDOWN                        = st.shutdown;
  assign o_TERM_DSG_ALARM                  = st.term_alarm;
  assign o_PERM_FAIL                       = st.perm_fail;
  assign o_MANUFACTURER_ACCESS_SYS_PRESENT = st.sys_present;

endmodule

// ---- pstm_monitor_properties.sv ----
// port-level assertions for the threshold monitor
`timescale 1ns/1ps
module pstm_monitor_properties (
  // clock and reset
  input wire logic        I_SYS_CLK,
  input wire logic        I_RST_N,
  // watched ports
  input wire logic        i_PSEL,
  input wire logic        i_PENABLE,
  input wire logic        i_CELL_UNDERVOLTAGE_FLAG,
  input wire logic [15:0] i_REQ_CHG_CURRENT,
  input wire logic        o_PREADY,
  input wire logic        o_PSLVERR,
  input wire logic [15:0] o_CHG_CURRENT,
  input wire logic [15:0] o_CHG_VOLTAGE,
  input wire logic        o_CHG_FET_ON,
  input wire logic        o_DSG_FET_ON,
  input wire logic        o_SHUTDOWN,
  input wire logic        o_TERM_DSG_ALARM,
  input wire logic        o_PERM_FAIL
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  property p_answer;
    i_PSEL && !i_PENABLE |=> o_PREADY;
  endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_err;
    o_PSLVERR |-> o_PREADY;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_inh_cur;
    o_CHG_CURRENT != $past(i_REQ_CHG_CURRENT) |-> o_CHG_CURRENT == 16'h0000;
  endproperty
  a_inh_cur: assert property (p_inh_cur) else $error("charge current neither request nor zero");
  property p_inh_pair;
    o_CHG_CURRENT == 16'h0000 && $past(i_REQ_CHG_CURRENT) != 16'h0000 |-> o_CHG_VOLTAGE == 16'h0000;
  endproperty
  a_inh_pair: assert property (p_inh_pair) else $error("voltage not zeroed with current");
  property p_sd_off;
    o_SHUTDOWN |-> !o_CHG_FET_ON && !o_DSG_FET_ON;
  endproperty
  a_sd_off: assert property (p_sd_off) else $error("fet on during shutdown");
  property p_sd_hold;
    o_SHUTDOWN |=> o_SHUTDOWN;
  endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("shutdown dropped");
  property p_pf_hold;
    o_PERM_FAIL |=> o_PERM_FAIL;
  endproperty
  a_pf_hold: assert property (p_pf_hold) else $error("permanent failure dropped");
  property p_term;
    $past(o_TERM_DSG_ALARM) && $past(i_CELL_UNDERVOLTAGE_FLAG) && i_CELL_UNDERVOLTAGE_FLAG |-> o_TERM_DSG_ALARM;
  endproperty
  a_term: assert property (p_term) else $error("alarm cleared under cell undervoltage");
endmodule
bind pstm_monitor pstm_monitor_properties i_props (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .i_PSEL(i_PSEL), .i_PENABLE(i_PENABLE),
  .i_CELL_UNDERVOLTAGE_FLAG(i_CELL_UNDERVOLTAGE_FLAG), .i_REQ_CHG_CURRENT(i_REQ_CHG_CURRENT),
  .o_PREADY(o_PREADY), .o_PSLVERR(o_PSLVERR), .o_CHG_CURRENT(o_CHG_CURRENT), .o_CHG_VOLTAGE(o_CHG_VOLTAGE),
  .o_CHG_FET_ON(o_CHG_FET_ON), .o_DSG_FET_ON(o_DSG_FET_ON), .o_SHUTDOWN(o_SHUTDOWN),
  .o_TERM_DSG_ALARM(o_TERM_DSG_ALARM), .o_PERM_FAIL(o_PERM_FAIL));

// ---- pstm_persist.sv ----
// sticky detector: condition held continuously for a number of second ticks
`timescale 1ns/1ps
module pstm_persist #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // condition, time base, limit
  input  wire logic         i_cond,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_limit,
  input  wire logic         i_clear,
  // result
  output logic              o_fired
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         fired;
  } persist_state_t;

  persist_state_t st;
  persist_state_t next_st;

  always_comb begin
    next_st = st;
    if (!i_cond) begin
      next_st.count = '0;
    end else if (i_tick && st.count != i_limit) begin
      next_st.count = st.count + 1'b1;
    end
    // a fresh detection beats a clear in the same cycle
    if (i_clear) begin
      next_st.fired = 1'b0;
    end
    if (i_cond && st.count == i_limit) begin
      next_st.fired = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_fired = st.fired;

endmodule

// ---- pstm_pkg.sv ----
// types shared by the threshold monitor modules
package pstm_pkg;

  typedef enum logic [1:0] {
    CHG_RUN,
    CHG_PAUSED,
    CHG_WAIT_WINDOW
  } chg_state_t;

endpackage

// ---- pstm_sync3.sv ----
// three-flop pin synchroniser; output moves once the last two stages agree
`timescale 1ns/1ps
module pstm_sync3 (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // pin and clean level
  input  wire logic i_pin,
  output logic      o_level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = i_pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_level = st.level;

endmodule

// ---- testbench.sv ----
// self-checking bench for the threshold monitor
`timescale 1ns/1ps
`include "pstm_defs.svh"
module testbench;
  logic        clk, rst_n, psel, pen, pwr, mv, cuv, adp, pck, pready, pslverr, cfet, dfet, sd, sys, term, pf, cg, dg, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] temp, cur, volt, rqc, rqv, occ, ocv;
  int          err_count, cmp_count, cyc;
  logic [9:0]  ci [5] = '{`PSTM_IDX_DRAIN_HOT, `PSTM_IDX_DRAIN_HOT_RECOVER, `PSTM_IDX_CHG_PAUSE_HOT,
                          `PSTM_IDX_CHG_BLOCK_HOT, `PSTM_IDX_TEMP_TRIM};
  logic [31:0] cd [5] = '{32'h190, 32'h15E, 32'h15E, 32'h12C, 32'hF6};
  pstm_monitor #(.TICK_CYCLES(10)) i_dut (
    .I_SYS_CLK(clk), .I_RST_N(rst_n), .i_PSEL(psel), .i_PENABLE(pen), .i_PWRITE(pwr), .i_PADDR(paddr),
    .i_PWDATA(pwdata), .o_PREADY(pready), .o_PRDATA(prdata), .o_PSLVERR(pslverr), .i_MEAS_VALID(mv),
    .i_TEMP_RAW(temp), .i_CURRENT_RAW(cur), .i_PACK_VOLT(volt), .i_CELL_UNDERVOLTAGE_FLAG(cuv),
    .i_REQ_CHG_CURRENT(rqc), .i_REQ_CHG_VOLTAGE(rqv), .i_ADAPTER_PRESENT(adp), .i_PACK_PRESENT(pck),
    .o_CHG_CURRENT(occ), .o_CHG_VOLTAGE(ocv), .o_CHG_FET_ON(cfet), .o_DSG_FET_ON(dfet), .o_SHUTDOWN(sd),
    .o_MANUFACTURER_ACCESS_SYS_PRESENT(sys), .o_TERM_DSG_ALARM(term), .o_PERM_FAIL(pf));
  pstm_afe_model i_afe (.i_chg_on(cfet), .i_dsg_on(dfet), .i_shutdown(sd), .o_chg_gate(cg), .o_dsg_gate(dg));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  // outputs settle two edges later
  task automatic meas(input logic [15:0] t, input logic [15:0] c, input logic [15:0] v, input logic u);
    @(posedge clk);
    temp <= t;
    cur <= c;
    volt <= v;
    cuv <= u;
    mv <= 1;
    @(posedge clk);
    mv <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic init();
    @(posedge clk);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 5; i++) apb(1, ci[i], cd[i]);
  endtask
  task automatic t_regs();
    apb(0, `PSTM_IDX_START_HIGH, 0);
    chk("start_high", {16'h0000, `PSTM_RST_START_HIGH}, rd);
    apb(0, `PSTM_IDX_CHG_BLOCK_HOT, 0);
    chk("block_hot", 32'h12C, rd);
    apb(1, 10'h3FF, 32'hFFFFFFFF);
    chk("slverr", 1, er);
    apb(0, 10'h3FF, 0);
    chk("unmapped", 0, rd);
  endtask
  task automatic t_inhibit();
    meas(16'd305, 0, 16'd12000, 0);
    chk("chg_cur", 32'h3E8, occ);
    meas(16'd315, 0, 16'd12000, 0);
    chk("chg_cur", 0, occ);
    chk("chg_volt", 0, ocv);
  endtask
  task automatic t_drain();
    apb(1, `PSTM_IDX_OFF_CHG_LEAK, 32'hC8);
    apb(1, `PSTM_IDX_SWITCH_FAULT_SEC, 32'h2);
    meas(16'd415, 16'd500, 16'd12000, 0);
    chk("dsg_fet", 0, dfet);
    chk("chg_fet", 0, cfet);
    chk("sys_present", 1, sys);
    apb(0, `PSTM_IDX_STATUS, 0);
    chk("fet_fail_early", 0, rd[`PSTM_ST_CHG_FET_FAIL]);
    chk("pause", 1, rd[`PSTM_ST_PAUSE]);
    meas(16'd370, 16'd500, 16'd12000, 0);
    chk("dsg_hold", 0, dfet);
    repeat (40) @(posedge clk);
    apb(0, `PSTM_IDX_STATUS, 0);
    chk("fet_fail", 1, rd[`PSTM_ST_CHG_FET_FAIL]);
    meas(16'd355, 0, 16'd12000, 0);
    chk("dsg_back", 1, dfet);
    @(posedge clk) pck <= 0;
    repeat (8) @(posedge clk);
    apb(0, `PSTM_IDX_STATUS, 0);
    chk("fail_cleared", 0, rd[`PSTM_ST_CHG_FET_FAIL]);
    chk("pause", 0, rd[`PSTM_ST_PAUSE]);
    pck <= 1;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_band();
    apb(1, `PSTM_IDX_IGNORE_BAND, 32'h32);
    apb(1, `PSTM_IDX_COULOMB_TRIM, 32'hF6);
    apb(1, `PSTM_IDX_CONTROL, 32'h2);
    meas(16'd200, 16'd55, 16'd12000, 0);
    apb(0, `PSTM_IDX_STATUS, 0);
    chk("charging", 0, rd[`PSTM_ST_CHARGING]);
    meas(16'd200, 16'd60, 16'd12000, 0);
    apb(0, `PSTM_IDX_STATUS, 0);
    chk("charging", 1, rd[`PSTM_ST_CHARGING]);
    meas(16'd200, 16'hFFC4, 16'd12000, 0);
    apb(0, `PSTM_IDX_STATUS, 0);
    chk("draining", 1, rd[`PSTM_ST_DRAINING]);
    chk("perm_fail", 1, pf);
  endtask
  task automatic t_term();
    apb(1, `PSTM_IDX_DSG_END_VOLT, 32'h2710);
    meas(16'd200, 0, 16'd9000, 0);
    chk("term", 1, term);
    meas(16'd200, 0, 16'd11000, 1);
    chk("term", 1, term);
    meas(16'd200, 0, 16'd11000, 0);
    chk("term", 0, term);
  endtask
  task automatic t_shut();
    apb(1, `PSTM_IDX_POWER_OFF_VOLT, 32'h1388);
    meas(16'd200, 0, 16'd4000, 0);
    chk("shutdown", 1, sd);
    chk("gates", 0, {cg, dg, cfet, dfet});
  endtask
  task automatic t_fatal();
    apb(1, `PSTM_IDX_CONTROL, 32'h1);
    apb(1, `PSTM_IDX_FATAL_DRAIN_HOT, 32'h1F4);
    apb(1, `PSTM_IDX_FATAL_CHG_HOT, 32'h1F4);
    meas(16'd515, 16'hFF9C, 16'd12000, 0);
    chk("perm_fail", 0, pf);
    meas(16'd515, 16'd100, 16'd12000, 0);
    chk("perm_fail", 1, pf);
  endtask
  initial begin
    {psel, pen, pwr, mv, cuv, rst_n} = 0;
    {adp, pck} = 2'b11;
    paddr = 0;
    pwdata = 0;
    {temp, cur} = 0;
    volt = 16'd12000;
    rqc = 16'h03E8;
    rqv = 16'h2EE0;
    init();
    t_regs();
    t_inhibit();
    t_drain();
    t_band();
    t_term();
    t_shut();
    init();
    t_fatal();
    end_sim();
  end
endmodule
